// ==== core/acq_pkg.sv ====
// shared constants and carrier types for the acquisition bus control block
package acq_pkg;
  localparam int ACQ_BITS = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int HOLD_DELAY_NS = 50;
  localparam int HOLD_DELAY_CYC =
    (HOLD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HOLD_CNT_MAX = 4'(HOLD_DELAY_CYC);
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] DAC_RST = 8'h00;
  localparam logic [7:0] SAR_CLR = 8'h00;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [2:0] BIT_LSB = 3'h0;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_HOLD = 2'b01,
    ACQ_WAIT = 2'b10,
    ACQ_CONV = 2'b11
  } acq_state_e;

  // bus control pins as sampled by the block
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic st_n;
    logic cclk;
    logic clr_n;
  } acq_ctl_s;
endpackage

// ==== core/acq_conv_ctl.sv ====
// conversion sequencer, bus drive and output-converter register
module acq_conv_ctl
  import acq_pkg::*;
#(
  parameter int BITS = ACQ_BITS
)
(
  input wire logic mclk, // system clock, 250 mhz
  input wire logic rst_n, // synchronous reset of the sequencer
  input wire logic clk_en, // freezes all state when low
  input wire logic cs_n, // bus select pin
  input wire logic rd_n, // read strobe pin
  input wire logic wr_n, // load strobe pin
  input wire logic sample_trigger_n, // falling-edge start pin
  input wire logic conv_clk, // external conversion clock pin
  input wire logic dac_clear_n, // clear pin for register and done
  input wire logic [BITS-1:0] data_bus_i, // data bus in
  input wire logic comp_hi, // comparator: input above trial value
  output logic [BITS-1:0] data_bus_o, // data bus out
  output logic data_bus_oe, // bus drive enable
  output logic busy_n, // low while converting
  output logic done_n, // low when a result awaits
  output logic track_hold, // high while holding
  output logic [BITS-1:0] trial_code, // trial code to comparator dac
  output logic [BITS-1:0] dac_code // output-converter register
);

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  acq_ctl_s pin_a_r, pin_a_nxt;
  acq_ctl_s pin_b_r, pin_b_nxt;
  acq_ctl_s pin_c_r, pin_c_nxt;
  logic [BITS-1:0] bus_a_r, bus_a_nxt;
  logic [BITS-1:0] bus_b_r, bus_b_nxt;
  logic comp_a_r, comp_a_nxt;
  logic comp_b_r, comp_b_nxt;

  always_comb
  begin
    pin_a_nxt = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n,
                  st_n: sample_trigger_n, cclk: conv_clk,
                  clr_n: dac_clear_n};
    pin_b_nxt = pin_a_r;
    pin_c_nxt = pin_b_r;
    bus_a_nxt = data_bus_i;
    bus_b_nxt = bus_a_r;
    comp_a_nxt = comp_hi;
    comp_b_nxt = comp_a_r;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_a_r <= '1;
      pin_b_r <= '1;
      pin_c_r <= '1;
      bus_a_r <= '0;
      bus_b_r <= '0;
      comp_a_r <= 1'b0;
      comp_b_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_a_r <= pin_a_nxt;
      pin_b_r <= pin_b_nxt;
      pin_c_r <= pin_c_nxt;
      bus_a_r <= bus_a_nxt;
      bus_b_r <= bus_b_nxt;
      comp_a_r <= comp_a_nxt;
      comp_b_r <= comp_b_nxt;
    end
  end

  acq_ctl_s pin_s, pin_p;
  logic rd_start, st_start, cclk_fall, cs_rise, rd_rise, wr_rise;
  logic sel_read, start_ev;

  assign pin_s = pin_b_r;
  assign pin_p = pin_c_r;
  assign sel_read = !pin_s.cs_n && !pin_s.rd_n;
  // read mode start: trigger held high, select and read both low
  assign rd_start = pin_s.st_n && sel_read &&
                    (pin_p.cs_n || pin_p.rd_n);
  assign st_start = pin_p.st_n && !pin_s.st_n;
  assign cclk_fall = pin_p.cclk && !pin_s.cclk;
  assign cs_rise = !pin_p.cs_n && pin_s.cs_n;
  assign rd_rise = !pin_p.rd_n && pin_s.rd_n;
  assign wr_rise = !pin_p.wr_n && pin_s.wr_n;
  assign start_ev = rd_start || st_start;

  ////////////////////////////////////////////////////////////////
  // conversion sequencer
  acq_state_e state_r, state_nxt;
  logic [3:0] hold_cnt_r, hold_cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [BITS-1:0] sar_r, sar_nxt;
  logic [BITS-1:0] result_r, result_nxt;
  logic done_r, done_nxt;
  logic end_conv;

  always_comb
  begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    bit_nxt = bit_r;
    sar_nxt = sar_r;
    result_nxt = result_r;
    end_conv = 1'b0;
    unique case (state_r)
      ACQ_IDLE:
      begin
        // a clock edge alone never leaves idle
        if (start_ev)
        begin
          state_nxt = ACQ_HOLD;
          hold_cnt_nxt = '0;
          bit_nxt = BIT_MSB;
        end
      end
      ACQ_HOLD:
      begin
        // clock falls inside the 50 ns window do not count
        if (hold_cnt_r == HOLD_CNT_MAX)
          state_nxt = ACQ_WAIT;
        else
          hold_cnt_nxt = hold_cnt_r + 4'h1;
      end
      ACQ_WAIT:
      begin
        // first counted fall, decision on the next one
        if (cclk_fall)
        begin
          state_nxt = ACQ_CONV;
          sar_nxt[bit_r] = 1'b1;
        end
      end
      ACQ_CONV:
      begin
        if (cclk_fall)
        begin
          sar_nxt[bit_r] = comp_b_r;
          if (bit_r == BIT_LSB)
          begin
            end_conv = 1'b1;
            result_nxt = {sar_r[BITS-1:1], comp_b_r};
            sar_nxt = SAR_CLR;
            state_nxt = ACQ_IDLE;
          end
          else
          begin
            bit_nxt = bit_r - 3'h1;
            sar_nxt[bit_r - 3'h1] = 1'b1;
          end
        end
      end
    endcase
  end

  // done: clear pin and read edges release it; a new end wins
  always_comb
  begin
    done_nxt = done_r;
    if (cs_rise || rd_rise || !pin_s.clr_n)
      done_nxt = 1'b0;
    if (end_conv)
      done_nxt = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r <= ACQ_IDLE;
      hold_cnt_r <= '0;
      bit_r <= BIT_MSB;
      sar_r <= SAR_CLR;
      result_r <= RESULT_RST;
      done_r <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      bit_r <= bit_nxt;
      sar_r <= sar_nxt;
      result_r <= result_nxt;
      done_r <= done_nxt;
    end
  end

  // clear pin forces done high without touching the conversion
  assign done_n = !(done_r && dac_clear_n);
  assign busy_n = (state_r == ACQ_IDLE);
  assign track_hold = (state_r != ACQ_IDLE);
  assign trial_code = sar_r;

  ////////////////////////////////////////////////////////////////
  // data bus drive
  logic [BITS-1:0] bus_out_r, bus_out_nxt;
  logic bus_oe_r, bus_oe_nxt;

  always_comb
  begin
    bus_out_nxt = result_r;
    bus_oe_nxt = sel_read;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bus_out_r <= RESULT_RST;
      bus_oe_r <= 1'b0;
    end
    else if (clk_en)
    begin
      bus_out_r <= bus_out_nxt;
      bus_oe_r <= bus_oe_nxt;
    end
  end

  assign data_bus_o = bus_out_r;
  assign data_bus_oe = bus_oe_r;

  ////////////////////////////////////////////////////////////////
  // output-converter register
  logic [BITS-1:0] dac_r, dac_nxt;
  logic dac_load;

  // edge of one strobe while the other stays low
  assign dac_load = (wr_rise && !pin_s.cs_n) ||
                    (cs_rise && !pin_s.wr_n);

  always_comb
  begin
    dac_nxt = dac_r;
    if (!pin_s.clr_n)
      dac_nxt = DAC_RST;
    else if (dac_load)
      dac_nxt = bus_b_r;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      dac_r <= DAC_RST;
    else if (clk_en)
      dac_r <= dac_nxt;
  end

  assign dac_code = dac_r;

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_start;
    state_r == ACQ_IDLE && start_ev;
  endsequence

  sequence s_hold_gap;
    state_r == ACQ_HOLD [*8];
  endsequence

  property p_busy_on_start;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    s_start |=> !busy_n && track_hold;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start)
    else $error("busy not low after start");

  property p_hold_gap;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    s_start |=> s_hold_gap;
  endproperty
  a_hold_gap: assert property (p_hold_gap)
    else $error("hold window too short");

  property p_no_self_start;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    state_r == ACQ_IDLE && !start_ev |=> state_r == ACQ_IDLE;
  endproperty
  a_no_self_start: assert property (p_no_self_start)
    else $error("conversion started without start event");

  property p_end_result;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    end_conv |=> busy_n && !track_hold && (!done_n || !dac_clear_n);
  endproperty
  a_end_result: assert property (p_end_result)
    else $error("end of conversion not signalled");

  property p_sar_clear;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    end_conv |=> sar_r == SAR_CLR &&
      result_r[BITS-1:1] == $past(sar_r[BITS-1:1]);
  endproperty
  a_sar_clear: assert property (p_sar_clear)
    else $error("approximation not cleared at end");

  property p_done_forced;
    @(posedge mclk) !dac_clear_n |-> done_n;
  endproperty
  a_done_forced: assert property (p_done_forced)
    else $error("done low while clear asserted");

  property p_done_release;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    (cs_rise || rd_rise) && !end_conv |=> done_n;
  endproperty
  a_done_release: assert property (p_done_release)
    else $error("done not released by read edge");

  property p_old_data;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    !busy_n |=> $stable(data_bus_o);
  endproperty
  a_old_data: assert property (p_old_data)
    else $error("bus shows partial result");

  property p_bus_drive;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    data_bus_oe |-> $past(sel_read);
  endproperty
  a_bus_drive: assert property (p_bus_drive)
    else $error("bus driven outside read");

  property p_dac_hold;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    !dac_load && pin_s.clr_n |=> $stable(dac_code);
  endproperty
  a_dac_hold: assert property (p_dac_hold)
    else $error("register changed without load");

  property p_dac_clear;
    @(posedge mclk) disable iff (!rst_n || !clk_en)
    !pin_s.clr_n |=> dac_code == DAC_RST;
  endproperty
  a_dac_clear: assert property (p_dac_clear)
    else $error("register not cleared");

endmodule

// ==== verification/acq_analog_model.sv ====
// far-side model: free conversion clock and held comparator input
module acq_analog_model
  import acq_pkg::*;
(
  input wire logic [7:0] vin, // analog input as a code
  input wire logic track_hold, // high while holding
  input wire logic [7:0] trial_code, // trial code from block
  output logic conv_clk, // free-running 5 mhz clock
  output logic comp_hi // input above trial value
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] held;

  ////////////////////////////////////////////////////////////////////////
  // runs between conversions too, phase unrelated to mclk
  initial
  begin
    conv_clk = 1'b1;
    #37;
    forever #100 conv_clk = ~conv_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // sample freezes while holding
  always @(posedge track_hold) held = vin;
  // half-lsb offset: a mid-code input resolves to its own code
  assign comp_hi = {(track_hold ? held : vin), 1'b1} > {trial_code, 1'b0};
endmodule

// ==== verification/acq_conv_ctl_tb.sv ====
// self-checking bench: conversions, bus reads and register writes
module acq_conv_ctl_tb
  import acq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic sample_trigger_n = 1'b1;
  logic dac_clear_n = 1'b1;
  logic [7:0] host_d = 8'h00;
  logic [7:0] vin = 8'h00;
  logic conv_clk;
  logic comp_hi;
  logic data_bus_oe;
  logic busy_n;
  logic done_n;
  logic track_hold;
  logic [7:0] data_bus_i;
  logic [7:0] data_bus_o;
  logic [7:0] trial_code;
  logic [7:0] dac_code;
  int n_errors = 0;
  int n_tests = 0;
  int c;

  always #2 mclk = ~mclk;
  // shared bus wire: block wins while it drives
  assign data_bus_i = data_bus_oe ? data_bus_o : host_d;

  acq_conv_ctl acq_conv_ctl_inst (
    .mclk, .rst_n, .clk_en, .cs_n, .rd_n, .wr_n, .sample_trigger_n,
    .conv_clk, .dac_clear_n, .data_bus_i, .comp_hi, .data_bus_o,
    .data_bus_oe, .busy_n, .done_n, .track_hold, .trial_code, .dac_code
  );
  acq_analog_model acq_analog_model_inst (
    .vin, .track_hold, .trial_code, .conv_clk, .comp_hi
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // bounded wait for busy_n, cycles left in c
  task automatic wb(input logic lvl, input int lim);
    c = 0;
    while (busy_n !== lvl && c < lim)
    begin
      cyc(1);
      c++;
    end
    chk(busy_n === lvl, "busy wait timed out");
  endtask
  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    chk(busy_n === 1'b1 && done_n === 1'b1 && data_bus_oe === 1'b0, "rst");
    chk(dac_code === 8'h00, "reg reset value");
    // trigger pulse while frozen must never be seen
    clk_en = 1'b0;
    sample_trigger_n = 1'b0;
    cyc(10);
    chk(busy_n === 1'b1, "start taken while frozen");
    sample_trigger_n = 1'b1;
    cyc(2);
    clk_en = 1'b1;
    cyc(300);
    chk(busy_n === 1'b1, "clock alone started");
  endtask
  // trigger conversion; trigger stays low afterwards
  task automatic t_trig(input logic [7:0] v, input logic [7:0] prev);
    sample_trigger_n = 1'b1;
    cyc(4);
    vin = v;
    sample_trigger_n = 1'b0;
    wb(1'b0, 10);
    chk(track_hold === 1'b1, "no hold");
    cyc(20);
    vin = ~v;
    chk(data_bus_o === prev, "partial bits");
    wb(1'b1, 700);
    chk(c >= 380 && c <= 460, "conv length");
    chk(done_n === 1'b0 && track_hold === 1'b0, "end");
    chk(trial_code === 8'h00, "approx not cleared");
    cyc(2);
    chk(data_bus_o === v, "result");
  endtask
  task automatic t_read();
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(5);
    chk(busy_n === 1'b1, "read started in trigger mode");
    chk(data_bus_oe === 1'b1 && data_bus_i === 8'ha5, "read");
    rd_n = 1'b1;
    cyc(5);
    chk(done_n === 1'b1 && data_bus_oe === 1'b0, "done release");
    cs_n = 1'b1;
    cyc(3);
  endtask
  task automatic t_clear_mid();
    fork
      t_trig(8'h5a, 8'ha5);
      begin
        cyc(100);
        dac_clear_n = 1'b0;
        cyc(3);
        dac_clear_n = 1'b1;
      end
    join
    dac_clear_n = 1'b0;
    #1;
    chk(done_n === 1'b1, "clear did not force done high");
    cyc(1);
    dac_clear_n = 1'b1;
    cyc(3);
    chk(done_n === 1'b1, "done came back after clear");
  endtask
  task automatic t_read_mode();
    logic [7:0] prev;
    logic [7:0] v [2];
    prev = 8'h5a;
    v = '{8'hff, 8'h00};
    sample_trigger_n = 1'b1;
    cyc(4);
    for (int i = 0; i < 2; i++)
    begin
      vin = v[i];
      cs_n = 1'b0;
      rd_n = 1'b0;
      wb(1'b0, 10);
      chk(track_hold === 1'b1, "read start");
      cyc(20);
      chk(data_bus_oe === 1'b1 && data_bus_i === prev, "old");
      wb(1'b1, 700);
      chk(c >= 380 && c <= 460, "read conv length");
      cyc(2);
      chk(data_bus_i === v[i], "read result");
      rd_n = 1'b1;
      cs_n = 1'b1;
      cyc(5);
      chk(done_n === 1'b1 && data_bus_oe === 1'b0, "release");
      prev = v[i];
    end
  endtask
  // no conversion runs during writes
  task automatic t_write();
    host_d = 8'h81;
    cs_n = 1'b0;
    wr_n = 1'b0;
    cyc(3);
    host_d = 8'h7e;
    cyc(4);
    chk(dac_code === 8'h00, "reg followed bus");
    wr_n = 1'b1;
    cyc(5);
    chk(dac_code === 8'h7e, "load strobe write");
    cs_n = 1'b1;
    wr_n = 1'b0;
    cyc(2);
    cs_n = 1'b0;
    host_d = 8'hff;
    cyc(4);
    cs_n = 1'b1;
    cyc(5);
    chk(dac_code === 8'hff, "select edge write");
    host_d = 8'h01;
    wr_n = 1'b1;
    cyc(5);
    chk(dac_code === 8'hff, "write without select");
    dac_clear_n = 1'b0;
    cyc(5);
    dac_clear_n = 1'b1;
    cyc(5);
    chk(dac_code === 8'h00, "clear");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    t_idle();
    t_trig(8'ha5, 8'h00);
    t_read();
    t_clear_mid();
    t_read_mode();
    t_write();
    stop_test();
  end
  initial
  begin
    #100000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    stop_test();
  end
endmodule
